// >>> src/spi_master_pkg.sv
// Package with constants, carrier structs and state layout of the serial port.
package spi_master_pkg;

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  // Half serial clock periods in core cycles for each rate select code.
  localparam logic [7:0] HALF_RATE0 = 8'h02;
  localparam logic [7:0] HALF_RATE1 = 8'h04;
  localparam logic [7:0] HALF_RATE2 = 8'h08;
  localparam logic [7:0] HALF_RATE3 = 8'h10;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] SELECT_IDLE = 2'h3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // The closing state gives the synchronised master-in line one more cycle
  // to show the last bit at the fastest rate.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_LAST = 3'b100
  } xfer_state_e;

  typedef struct packed {
    logic rate_select_high;
    logic rate_select_low;
    logic clock_idle_polarity;
    logic clock_capture_phase;
    logic master_select_bit;
    logic port_enable_bit;
    logic transfer_irq_enable;
  } ctrl_s;

  typedef struct packed {
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
  } status_s;

  typedef struct packed {
    xfer_state_e fsm;
    ctrl_s       ctrl;
    status_s     stat;
    logic        sr_seen;
    logic        mode_fault_flag_armed;
    logic [7:0]  shreg;
    logic [7:0]  rxbuf;
    logic        sample;
    logic [7:0]  half_cnt;
    logic [3:0]  edge_cnt;
    logic        sck;
    logic [1:0]  ss_sync;
    logic [1:0]  miso_sync;
  } port_state_s;

  localparam ctrl_s CTRL_RESET = '0;
  localparam status_s STAT_RESET = '0;

  // Half period of the serial clock for the two rate select bits.
  function automatic logic [7:0] rate_half(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00:   rate_half = HALF_RATE0;
      2'b01:   rate_half = HALF_RATE1;
      2'b10:   rate_half = HALF_RATE2;
      default: rate_half = HALF_RATE3;
    endcase
  endfunction : rate_half

endpackage : spi_master_pkg

// >>> src/spi_master_transfer.sv
// Master mode serial peripheral port: control, status, shifter and clocking.
//
// Overview of operation
// - Each byte shifts out on master-out while one shifts in on master-in.
// - Bits travel most significant first in both directions.
// - As master the port makes the serial clock and drives it out.
// - Two rate select bits choose one of four serial bit rates.
// - Polarity and phase bits choose one of four clock/data relationships.
// - Master and enable bits stay set only while slave select is high.
// - As master, master-out is an output and master-in an input.
// - Writing the data byte loads the shifter and starts a transfer.
// - Completion of a byte sets the transfer complete flag.
// - Interrupt only when enable is set and the cpu mask is clear.
// - At completion the received byte is copied to the receive buffer.
// - Reading data returns the buffered byte, not the live shifter.
// - Complete flag clears by status access then data read or write.
// - Data writes are ignored while complete flag set until status read.
// - Polarity sets the serial clock idle level whenever no data moves.
// - Slave select low as master sets mode fault, drops enable and master.
// - Data write while bits shift is lost, flagged, transfer goes on.

`timescale 1ns/100ps

module spi_master_transfer (
  input  wire logic                   core_clk_in,        // Core clock.
  input  wire logic                   reset_in,           // Async reset.
  input  wire logic                   ctrl_wr_in,         // Control write.
  input  wire spi_master_pkg::ctrl_s  ctrl_in,            // Control value.
  output spi_master_pkg::ctrl_s       ctrl_out,           // Control state.
  input  wire logic                   status_access_in,   // Status access.
  output spi_master_pkg::status_s     status_out,         // Status flags.
  input  wire logic                   data_wr_in,         // Data write.
  input  wire logic                   data_rd_in,         // Data read.
  input  wire logic [7:0]             data_in,            // Write byte.
  output logic [7:0]                  data_out,           // Received byte.
  input  wire logic                   cpu_irq_mask_in,    // Global mask.
  output logic                        irq_out,            // Interrupt.
  output logic                        busy_out,           // Transfer on.
  output logic                        sck_out,            // Serial clock.
  output logic                        sck_oe_out,         // Clock enable.
  output logic                        mosi_out,           // Master out.
  output logic                        mosi_oe_out,        // Out enable.
  input  wire logic                   miso_in,            // Master in pin.
  input  wire logic                   slave_select_n_in   // Select pin.
);

  // ----------------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------------
  spi_master_pkg::port_state_s s;
  spi_master_pkg::port_state_s next_s;
  logic                        start;
  logic                        done;
  logic                        collide;
  logic                        blocked;
  logic                        last_half;
  logic                        is_sample;
  logic [7:0]                  new_byte;

  always_comb begin
    next_s    = s;
    start     = 1'b0;
    done      = 1'b0;
    collide   = 1'b0;
    new_byte  = s.shreg;
    is_sample = (s.edge_cnt[0] == s.ctrl.clock_capture_phase);
    last_half = (s.half_cnt == 8'(spi_master_pkg::rate_half(
                  s.ctrl.rate_select_high, s.ctrl.rate_select_low) - 8'h01));
    blocked   = s.stat.transfer_complete_flag && !s.sr_seen;
    next_s.ss_sync   = {s.ss_sync[0], slave_select_n_in};
    next_s.miso_sync = {s.miso_sync[0], miso_in};

    if (status_access_in) begin
      if (s.stat.transfer_complete_flag || s.stat.write_collision_flag) begin
        next_s.sr_seen = 1'b1;
      end
      if (s.stat.mode_fault_flag) begin
        next_s.mode_fault_flag_armed = 1'b1;
      end
    end
    if ((data_rd_in || data_wr_in) && s.sr_seen) begin
      next_s.stat.transfer_complete_flag = 1'b0;
      next_s.stat.write_collision_flag   = 1'b0;
      next_s.sr_seen                     = 1'b0;
    end

    if (ctrl_wr_in) begin
      next_s.ctrl = ctrl_in;
      if (s.stat.mode_fault_flag && !s.mode_fault_flag_armed) begin
        next_s.ctrl.master_select_bit = 1'b0;
        next_s.ctrl.port_enable_bit   = 1'b0;
      end
      if (s.mode_fault_flag_armed) begin
        next_s.stat.mode_fault_flag = 1'b0;
        next_s.mode_fault_flag_armed           = 1'b0;
      end
    end

    if (data_wr_in) begin
      if (s.fsm == spi_master_pkg::ST_XFER) begin
        collide = 1'b1;
        next_s.stat.write_collision_flag = 1'b1;
      end else if (!blocked
                   && s.fsm == spi_master_pkg::ST_IDLE) begin
        // A write in the closing cycle is dropped, as only ST_IDLE accepts it.
        next_s.shreg = data_in;
        if (s.ctrl.master_select_bit && s.ctrl.port_enable_bit) begin
          start           = 1'b1;
          next_s.fsm      = spi_master_pkg::ST_XFER;
          next_s.half_cnt = 8'h00;
          next_s.edge_cnt = 4'h0;
        end
      end
    end

    case (s.fsm)
      spi_master_pkg::ST_XFER: begin
        next_s.half_cnt = 8'(s.half_cnt + 8'h01);
        // Master-in is read one cycle after each capture edge: with two
        // sync stages the bit set up a half period earlier only shows then.
        if (s.half_cnt == 8'h00 && !is_sample) begin
          next_s.sample = s.miso_sync[1];
        end
        if (last_half) begin
          next_s.half_cnt = 8'h00;
          next_s.sck      = !s.sck;
          next_s.edge_cnt = 4'(s.edge_cnt + 4'h1);
          if (!is_sample && !(s.ctrl.clock_capture_phase
                              && s.edge_cnt == 4'h0)) begin
            next_s.shreg = {s.shreg[6:0], s.sample};
          end
          if (s.edge_cnt == spi_master_pkg::LAST_EDGE) begin
            next_s.fsm = spi_master_pkg::ST_LAST;
          end
        end
      end
      spi_master_pkg::ST_LAST: begin
        if (s.ctrl.clock_capture_phase) begin
          new_byte = {s.shreg[6:0], s.miso_sync[1]};
        end
        done         = 1'b1;
        next_s.shreg = new_byte;
        next_s.rxbuf = new_byte;
        next_s.fsm   = spi_master_pkg::ST_IDLE;
        next_s.stat.transfer_complete_flag = 1'b1;
      end
      spi_master_pkg::ST_IDLE: begin
        next_s.sck = next_s.ctrl.clock_idle_polarity;
      end
      default: begin
        next_s.fsm = spi_master_pkg::ST_IDLE;
      end
    endcase

    if (s.ctrl.master_select_bit && !s.ss_sync[1]) begin
      next_s.stat.mode_fault_flag   = 1'b1;
      next_s.ctrl.master_select_bit = 1'b0;
      next_s.ctrl.port_enable_bit   = 1'b0;
      next_s.fsm                    = spi_master_pkg::ST_IDLE;
      next_s.sck                    = s.ctrl.clock_idle_polarity;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= '{fsm: spi_master_pkg::ST_IDLE,
             ctrl: spi_master_pkg::CTRL_RESET,
             stat: spi_master_pkg::STAT_RESET,
             shreg: spi_master_pkg::BYTE_RESET,
             rxbuf: spi_master_pkg::BYTE_RESET,
             ss_sync: spi_master_pkg::SELECT_IDLE,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign ctrl_out    = s.ctrl;
  assign status_out  = s.stat;
  assign data_out    = s.rxbuf;
  assign busy_out    = (s.fsm != spi_master_pkg::ST_IDLE);
  assign sck_out     = s.sck;
  assign sck_oe_out  = s.ctrl.master_select_bit && s.ctrl.port_enable_bit;
  assign mosi_out    = s.shreg[7];
  assign mosi_oe_out = sck_oe_out;
  assign irq_out     = s.ctrl.transfer_irq_enable && !cpu_irq_mask_in
                       && (s.stat.transfer_complete_flag
                           || s.stat.mode_fault_flag);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  AST_FULL_DUPLEX: assert property (
    busy_out |-> (sck_oe_out && mosi_oe_out))
    else $error("transfer running without driven clock and data");
  AST_MSB_FIRST: assert property (
    start |=> (mosi_out == $past(data_in[7]) && busy_out))
    else $error("first bit out is not the written msb");
  AST_IDLE_LEVEL: assert property (
    (!busy_out && $past(!busy_out) && $stable(ctrl_out))
      |-> (sck_out == ctrl_out.clock_idle_polarity))
    else $error("serial clock idle level wrong");
  AST_HALF_PERIOD: assert property (
    (busy_out && $changed(sck_out)) |=> $stable(sck_out))
    else $error("serial clock half period too short");
  AST_DONE_FLAG: assert property (
    done |=> (status_out.transfer_complete_flag && !busy_out))
    else $error("complete flag not set after byte");
  AST_RX_BUFFER: assert property (
    done |=> (data_out == $past(new_byte)))
    else $error("receive buffer not loaded at completion");
  AST_IRQ: assert property (
    irq_out |-> (ctrl_out.transfer_irq_enable && !cpu_irq_mask_in))
    else $error("interrupt raised while disabled");
  AST_MODE_FAULT: assert property (
    (ctrl_out.master_select_bit && !s.ss_sync[1])
      |=> (status_out.mode_fault_flag && !ctrl_out.master_select_bit
           && !ctrl_out.port_enable_bit && !busy_out))
    else $error("mode fault not taken");
  AST_COLLISION: assert property (
    collide |=> (status_out.write_collision_flag && busy_out))
    else $error("collision not flagged or transfer stopped");
  AST_WRITE_BLOCK: assert property (
    (data_wr_in && blocked && !busy_out) |=> !busy_out)
    else $error("blocked write started a transfer");
  AST_FLAG_HOLD: assert property (
    (status_out.transfer_complete_flag && !s.sr_seen)
      |=> status_out.transfer_complete_flag)
    else $error("complete flag cleared without status access");

  COV_BYTE_DONE: cover property (start ##[1:600] done);
  COV_COLLIDE: cover property (collide);
  COV_FAULT: cover property (status_out.mode_fault_flag);
  COV_CLEAR: cover property (
    status_out.transfer_complete_flag ##1 !status_out.transfer_complete_flag);

endmodule : spi_master_transfer

// >>> sim/spi_slave_model.sv
// Behavioural serial slave that answers the master byte for byte.
`timescale 1ns/100ps
module spi_slave_model (
  input  wire logic       sck_in,   // Serial clock.
  input  wire logic       mosi_in,  // Master out data.
  input  wire logic       clock_idle_polarity_in,  // Idle clock level.
  input  wire logic       clock_capture_phase_in,  // Capture phase.
  input  wire logic       frame_in, // Selected by bench.
  input  wire logic [7:0] tx_in,    // Answer byte.
  output logic            miso_out, // Master in data.
  output logic [7:0]      rx_out    // Captured byte.
);
  logic [7:0] shift;
  logic       lead;
  initial miso_out = 1'b0;
  always @(posedge frame_in) begin
    shift = tx_in;
    miso_out = tx_in[7];
  end
  // Released line shows the inverse of its last value.
  always @(negedge frame_in) miso_out = ~miso_out;
  always @(sck_in) begin
    if (frame_in) begin
      lead = (sck_in != clock_idle_polarity_in);
      if (lead != clock_capture_phase_in) begin
        rx_out = {rx_out[6:0], mosi_in};
      end else if (clock_capture_phase_in) begin
        miso_out = shift[7];
        shift = shift << 1;
      end else begin
        shift = shift << 1;
        miso_out = shift[7];
      end
    end
  end
endmodule : spi_slave_model

// >>> sim/testbench.sv
// Self-checking bench for the master serial port.
`timescale 1ns/100ps
module testbench;
  logic                    core_clk_in, reset_in, ctrl_wr_in, frame;
  logic                    status_access_in, data_wr_in, data_rd_in;
  logic                    cpu_irq_mask_in, slave_select_n_in, miso;
  logic                    irq_out, busy_out, sck_out, sck_oe_out;
  logic                    mosi_out, mosi_oe_out;
  logic [7:0]              data_in, data_out, slave_tx, slave_rx;
  spi_master_pkg::ctrl_s   ctrl_in, ctrl_out;
  spi_master_pkg::status_s status_out;
  int                      error_cnt, tests_run, busy_cyc;

  spi_master_transfer i_spi_master_transfer (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .ctrl_wr_in(ctrl_wr_in), .ctrl_in(ctrl_in),
    .ctrl_out(ctrl_out), .status_access_in(status_access_in),
    .status_out(status_out), .data_wr_in(data_wr_in),
    .data_rd_in(data_rd_in), .data_in(data_in), .data_out(data_out),
    .cpu_irq_mask_in(cpu_irq_mask_in), .irq_out(irq_out),
    .busy_out(busy_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
    .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .miso_in(miso),
    .slave_select_n_in(slave_select_n_in));
  spi_slave_model i_spi_slave_model (.sck_in(sck_out),
    .mosi_in(mosi_out), .clock_idle_polarity_in(ctrl_out.clock_idle_polarity),
    .clock_capture_phase_in(ctrl_out.clock_capture_phase), .frame_in(frame),
    .tx_in(slave_tx), .miso_out(miso), .rx_out(slave_rx));

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (busy_out === 1'b1) busy_cyc++;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask : pulse
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Mode m picks rate, polarity and phase; collide writes again two cycles into the byte.
  task automatic xfer(input logic [1:0] m, input logic [7:0] tx,
                      input logic [7:0] stx, input logic collide);
    ctrl_in = {m, m, 3'b111};
    slave_tx = stx;
    pulse(ctrl_wr_in);
    chk(sck_out, m[1]);
    chk({sck_oe_out, mosi_oe_out}, 2'b11);
    frame = 1'b1;
    busy_cyc = 0;
    data_in = tx;
    pulse(data_wr_in);
    chk(busy_out, 1'b1);
    if (!m[0]) chk(mosi_out, tx[7]);
    if (collide) begin
      data_in = ~tx;
      pulse(data_wr_in);
    end
    for (int i = 0; i < 1000 && busy_out !== 1'b0; i++) tick();
    if (busy_out !== 1'b0) begin
      error_cnt++;
      tally_and_finish();
    end
    chk(busy_cyc, 16'((32 << m) + 1));
    chk(status_out, {1'b1, collide, 1'b0});
    chk(data_out, stx);
    chk(slave_rx, tx);
    chk(irq_out, 1'b1);
    cpu_irq_mask_in = 1'b1;
    tick();
    chk(irq_out, 1'b0);
    cpu_irq_mask_in = 1'b0;
    data_in = 8'h5a;
    pulse(data_wr_in);
    chk(busy_out, 1'b0);
    pulse(status_access_in);
    pulse(data_rd_in);
    chk(status_out, 3'b000);
    chk(data_out, stx);
    frame = 1'b0;
  endtask : xfer

  task automatic mode_fault;
    slave_select_n_in = 1'b0;
    tick(5);
    chk(status_out, 3'b001);
    chk({ctrl_out.master_select_bit, ctrl_out.port_enable_bit}, 0);
    chk({sck_oe_out, irq_out}, 2'b01);
    slave_select_n_in = 1'b1;
    tick(3);
    pulse(ctrl_wr_in);
    chk(ctrl_out.master_select_bit, 1'b0);
    pulse(status_access_in);
    pulse(ctrl_wr_in);
    chk({status_out, ctrl_out.master_select_bit}, 4'h1);
  endtask : mode_fault

  initial begin
    {ctrl_wr_in, status_access_in, data_wr_in, data_rd_in} = '0;
    {cpu_irq_mask_in, frame, error_cnt, tests_run, busy_cyc} = '0;
    ctrl_in = '0;
    data_in = 8'h00;
    slave_tx = 8'h00;
    slave_select_n_in = 1'b1;
    reset_in = 1'b1;
    tick(20);
    reset_in = 1'b0;
    chk({status_out, data_out, sck_out, busy_out, irq_out}, 0);
    tick();
    for (int i = 0; i < 4; i++) begin
      xfer(2'(i), 8'h81 ^ 8'(i * 37), 8'h3c ^ 8'(i * 91), i == 2);
    end
    mode_fault();
    tally_and_finish();
  end
endmodule : testbench
